// ---- design/uied_ep0.v ----
// One direction of endpoint 0: configuration and byte count registers.
// Assumes completion and setup pulses on hclk from the buffer manager.
`timescale 1ns/1ps
`default_nettype none
`include "uied_regs.vh"

module uied_ep0 #(
	parameter IS_IN = 1
) (
	input wire hclk,
	input wire hresetn,
	input wire wr_cfg,
	input wire wr_cnt,
	input wire [7:0] wdata,
	input wire ack,
	input wire setup,
	input wire [3:0] rx_count,
	output wire [7:0] cfg,
	output wire [7:0] cnt,
	output wire [3:0] eff_count,
	output wire done
);
	reg manager_use_enable, toggle, stall, ie, nak;
	reg [3:0] count;

	assign cfg = {manager_use_enable, 1'b0, toggle, 1'b0, stall, ie, 2'b00};
	assign cnt = {nak, 3'b000, count};
	// Reserved codes act as a full packet
	assign eff_count = (count > `UIED_EP0_MAX_COUNT) ? `UIED_EP0_MAX_COUNT : count;
	assign done = ack & manager_use_enable & ~stall;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			manager_use_enable <= 1'b0;
			toggle <= 1'b0;
			stall <= 1'b0;
			ie <= 1'b0;
			nak <= `UIED_CNT0_NAK_RESET;
			count <= 4'h0;
		end else begin
			if (wr_cfg) begin
				manager_use_enable <= wdata[`UIED_B_MANAGER_USE_ENABLE];
				ie <= wdata[`UIED_B_IE];
			end
			// A setup ends any stall, even one written in the same cycle
			if (setup)
				stall <= 1'b0;
			else if (wr_cfg)
				stall <= wdata[`UIED_B_STALL];
			// Data stage after a setup always starts with DATA1
			if (setup)
				toggle <= 1'b1;
			else if (done)
				toggle <= ~toggle;
			if (done)
				nak <= 1'b1;
			else if (wr_cnt)
				nak <= wdata[`UIED_B_NAK];
			if (done && IS_IN == 0)
				count <= rx_count;
			else if (wr_cnt)
				count <= wdata[3:0];
		end
	end
endmodule // uied_ep0

`default_nettype wire

// ---- design/uied_in_ep.v ----
// One input endpoint (1 to 3): configuration, Y byte count and X/Y buffer size.
// Assumes write strobes and completion pulses on hclk from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "uied_regs.vh"

module uied_in_ep (
	input wire hclk,
	input wire hresetn,
	input wire wr_cfg,
	input wire wr_ycnt,
	input wire wr_size,
	input wire [7:0] wdata,
	input wire ack,
	output wire [7:0] cfg,
	output wire [7:0] ycnt,
	output wire [7:0] size,
	output wire y_sel,
	output wire done
);
	reg manager_use_enable, iso, toggle, double_buffer_enable, stall, ie;
	reg y_nak;
	reg [6:0] y_count;
	reg [6:0] buf_size;

	assign cfg = {manager_use_enable, iso, toggle, double_buffer_enable, stall, ie, 2'b00};
	assign ycnt = {y_nak, y_count};
	assign size = {1'b0, buf_size};
	assign y_sel = double_buffer_enable & toggle;
	assign done = ack & manager_use_enable & ~stall;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			manager_use_enable <= 1'b0;
			iso <= 1'b0;
			toggle <= 1'b0;
			double_buffer_enable <= 1'b0;
			stall <= 1'b0;
			ie <= 1'b0;
			y_nak <= 1'b1;
			y_count <= 7'h00;
			buf_size <= 7'h00;
		end else begin
			if (wr_cfg) begin
				manager_use_enable <= wdata[`UIED_B_MANAGER_USE_ENABLE];
				iso <= wdata[`UIED_B_ISO];
				double_buffer_enable <= wdata[`UIED_B_DOUBLE_BUFFER_ENABLE];
				stall <= wdata[`UIED_B_STALL];
				ie <= wdata[`UIED_B_IE];
			end
			// Hardware flip beats a same-cycle write
			if (done)
				toggle <= ~toggle;
			else if (wr_cfg)
				toggle <= wdata[`UIED_B_TOGGLE];
			if (wr_ycnt)
				y_count <= wdata[6:0];
			// Only software clears the flag; a sent Y packet sets it
			if (done && y_sel)
				y_nak <= 1'b1;
			else if (wr_ycnt)
				y_nak <= wdata[`UIED_B_NAK];
			if (wr_size)
				buf_size <= wdata[6:0];
		end
	end
endmodule // uied_in_ep

`default_nettype wire

// ---- design/uied_regs.vh ----
// Register indices, field positions and reset values of the endpoint descriptor block.
// Byte address on the bus is four times the register index.
`ifndef UIED_REGS_VH
`define UIED_REGS_VH

// Endpoint 1 to 3 descriptor bases and offsets within a descriptor
`define UIED_EP1_BASE 16'hff48
`define UIED_EP2_BASE 16'hff50
`define UIED_EP3_BASE 16'hff58
`define UIED_OFS_CFG 16'h0000
`define UIED_OFS_YCNT 16'h0006
`define UIED_OFS_SIZE 16'h0007

// Endpoint 0 fixed registers
`define UIED_EP0_IN_CFG 16'hff80
`define UIED_EP0_IN_CNT 16'hff81
`define UIED_EP0_OUT_CFG 16'hff82
`define UIED_EP0_OUT_CNT 16'hff83

// Interrupt status and mask
`define UIED_IRQ_STATUS 16'hff90
`define UIED_IRQ_MASK 16'hff91

// Hardwired endpoint 0 buffer bases
`define UIED_EP0_OUT_BUF 16'hfef0
`define UIED_EP0_IN_BUF 16'hfef8

// Field positions
`define UIED_B_MANAGER_USE_ENABLE 7
`define UIED_B_ISO 6
`define UIED_B_TOGGLE 5
`define UIED_B_DOUBLE_BUFFER_ENABLE 4
`define UIED_B_STALL 3
`define UIED_B_IE 2
`define UIED_B_NAK 7

// Status bit positions
`define UIED_S_EP0_IN 0
`define UIED_S_EP0_OUT 4

// Limits and reset values
`define UIED_EP0_MAX_COUNT 4'h8
`define UIED_YCNT_RESET 8'h80
`define UIED_CNT0_RESET 8'h80
`define UIED_CNT0_NAK_RESET 1'b1
`define UIED_STATUS_W 5

// Register select codes
`define UIED_SEL_NONE 4'h0
`define UIED_SEL_E0I_CFG 4'h1
`define UIED_SEL_E0I_CNT 4'h2
`define UIED_SEL_E0O_CFG 4'h3
`define UIED_SEL_E0O_CNT 4'h4
`define UIED_SEL_STATUS 4'h5
`define UIED_SEL_MASK 4'h6
`define UIED_SEL_CFG1 4'h7
`define UIED_SEL_YCNT1 4'ha
`define UIED_SEL_SIZE1 4'hd

`endif

// ---- design/uied_top.v ----
// Endpoint descriptor registers for input endpoints 1 to 3 and endpoint 0,
// with an AHB-Lite slave port and one level interrupt.
// Assumes the buffer manager drives its pulses synchronously to hclk.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "uied_regs.vh"

module uied_top #(
	parameter N_EP = 3
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire [N_EP:0] in_ack,
	input wire setup_seen,
	input wire out0_ack,
	input wire [3:0] out0_rx_count,
	output wire [N_EP:0] in_ep_serve,
	output wire ep0_out_serve,
	output wire ep0_in_stall,
	output wire ep0_out_stall,
	output wire ep0_in_nak,
	output wire ep0_out_nak,
	output wire ep0_in_toggle,
	output wire ep0_out_toggle,
	output wire [3:0] ep0_in_count,
	output wire [15:0] ep0_in_buf_base,
	output wire [15:0] ep0_out_buf_base,
	output wire [N_EP-1:0] in_ep_stall,
	output wire [N_EP-1:0] in_ep_toggle,
	output wire [N_EP-1:0] in_ep_y_sel,
	output wire [N_EP-1:0] in_ep_y_nak,
	output wire [7*N_EP-1:0] in_ep_y_count,
	output wire [7*N_EP-1:0] in_ep_buf_size,
	output wire irq
);
	// Map a register index to a select code; used for writes and reads
	function [3:0] uied_decode;
		input [15:0] idx;
		begin
			case (idx)
				`UIED_EP0_IN_CFG: uied_decode = `UIED_SEL_E0I_CFG;
				`UIED_EP0_IN_CNT: uied_decode = `UIED_SEL_E0I_CNT;
				`UIED_EP0_OUT_CFG: uied_decode = `UIED_SEL_E0O_CFG;
				`UIED_EP0_OUT_CNT: uied_decode = `UIED_SEL_E0O_CNT;
				`UIED_IRQ_STATUS: uied_decode = `UIED_SEL_STATUS;
				`UIED_IRQ_MASK: uied_decode = `UIED_SEL_MASK;
				`UIED_EP1_BASE + `UIED_OFS_CFG: uied_decode = `UIED_SEL_CFG1;
				`UIED_EP2_BASE + `UIED_OFS_CFG: uied_decode = `UIED_SEL_CFG1 + 4'h1;
				`UIED_EP3_BASE + `UIED_OFS_CFG: uied_decode = `UIED_SEL_CFG1 + 4'h2;
				`UIED_EP1_BASE + `UIED_OFS_YCNT: uied_decode = `UIED_SEL_YCNT1;
				`UIED_EP2_BASE + `UIED_OFS_YCNT: uied_decode = `UIED_SEL_YCNT1 + 4'h1;
				`UIED_EP3_BASE + `UIED_OFS_YCNT: uied_decode = `UIED_SEL_YCNT1 + 4'h2;
				`UIED_EP1_BASE + `UIED_OFS_SIZE: uied_decode = `UIED_SEL_SIZE1;
				`UIED_EP2_BASE + `UIED_OFS_SIZE: uied_decode = `UIED_SEL_SIZE1 + 4'h1;
				`UIED_EP3_BASE + `UIED_OFS_SIZE: uied_decode = `UIED_SEL_SIZE1 + 4'h2;
				default: uied_decode = `UIED_SEL_NONE;
			endcase
		end
	endfunction

	// Bus slave: writes take no wait state, reads one
	wire take;
	wire in_window;
	wire [15:0] addr_idx;
	reg dp_wr;
	reg dp_rd;
	reg [15:0] dp_idx;
	wire [3:0] wsel;
	wire [3:0] rsel;
	wire wr_e0i_cfg;
	wire wr_e0i_cnt;
	wire wr_e0o_cfg;
	wire wr_e0o_cnt;
	wire wr_status;
	wire wr_mask;

	// Transfer size is ignored: every register is one byte in its own word
	assign take = hsel & hready & htrans[1];
	// Addresses beyond the register window land on an unmapped index
	assign in_window = (haddr[31:18] == 14'h0000);
	assign addr_idx = in_window ? haddr[17:2] : 16'h0000;
	assign hreadyout = ~dp_rd;
	assign hresp = 1'b0;
	assign wsel = dp_wr ? uied_decode(dp_idx) : `UIED_SEL_NONE;
	assign rsel = uied_decode(dp_idx);

	// One strobe per register, high in the write data phase only
	assign wr_e0i_cfg = (wsel == `UIED_SEL_E0I_CFG);
	assign wr_e0i_cnt = (wsel == `UIED_SEL_E0I_CNT);
	assign wr_e0o_cfg = (wsel == `UIED_SEL_E0O_CFG);
	assign wr_e0o_cnt = (wsel == `UIED_SEL_E0O_CNT);
	assign wr_status = (wsel == `UIED_SEL_STATUS);
	assign wr_mask = (wsel == `UIED_SEL_MASK);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr <= 1'b0;
			dp_rd <= 1'b0;
			dp_idx <= 16'h0000;
		end else begin
			dp_wr <= take & hwrite;
			dp_rd <= take & ~hwrite;
			if (take)
				dp_idx <= addr_idx;
		end
	end

	// Endpoint 0, both directions
	wire [7:0] e0i_cfg;
	wire [7:0] e0i_cnt;
	wire [7:0] e0o_cfg;
	wire [7:0] e0o_cnt;
	wire e0i_done;
	wire e0o_done;

	uied_ep0 #(.IS_IN(1)) u_ep0_in (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_cfg(wr_e0i_cfg),
		.wr_cnt(wr_e0i_cnt),
		.wdata(hwdata[7:0]),
		.ack(in_ack[0]),
		.setup(setup_seen),
		.rx_count(4'h0),
		.cfg(e0i_cfg),
		.cnt(e0i_cnt),
		.eff_count(ep0_in_count),
		.done(e0i_done)
	);

	uied_ep0 #(.IS_IN(0)) u_ep0_out (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_cfg(wr_e0o_cfg),
		.wr_cnt(wr_e0o_cnt),
		.wdata(hwdata[7:0]),
		.ack(out0_ack),
		.setup(setup_seen),
		.rx_count(out0_rx_count),
		.cfg(e0o_cfg),
		.cnt(e0o_cnt),
		.eff_count(),
		.done(e0o_done)
	);

	// Levels seen by the buffer manager
	assign in_ep_serve[0] = e0i_cfg[`UIED_B_MANAGER_USE_ENABLE];
	assign ep0_out_serve = e0o_cfg[`UIED_B_MANAGER_USE_ENABLE];
	assign ep0_in_stall = e0i_cfg[`UIED_B_STALL];
	assign ep0_out_stall = e0o_cfg[`UIED_B_STALL];
	assign ep0_in_nak = e0i_cnt[`UIED_B_NAK];
	assign ep0_out_nak = e0o_cnt[`UIED_B_NAK];
	assign ep0_in_toggle = e0i_cfg[`UIED_B_TOGGLE];
	assign ep0_out_toggle = e0o_cfg[`UIED_B_TOGGLE];
	assign ep0_in_buf_base = `UIED_EP0_IN_BUF;
	assign ep0_out_buf_base = `UIED_EP0_OUT_BUF;

	// Input endpoints 1 to N_EP
	wire [8*N_EP-1:0] ep_cfg;
	wire [8*N_EP-1:0] ep_ycnt;
	wire [8*N_EP-1:0] ep_size;
	wire [N_EP-1:0] ep_done;
	wire [N_EP-1:0] ep_event;
	genvar n;
	generate
		for (n = 0; n < N_EP; n = n + 1) begin : g_ep
			// Each endpoint decodes its own three write strobes
			localparam [3:0] EP_IDX = n;
			wire wr_cfg_ep;
			wire wr_ycnt_ep;
			wire wr_size_ep;

			assign wr_cfg_ep = (wsel == `UIED_SEL_CFG1 + EP_IDX);
			assign wr_ycnt_ep = (wsel == `UIED_SEL_YCNT1 + EP_IDX);
			assign wr_size_ep = (wsel == `UIED_SEL_SIZE1 + EP_IDX);

			uied_in_ep u_ep (
				.hclk(hclk),
				.hresetn(hresetn),
				.wr_cfg(wr_cfg_ep),
				.wr_ycnt(wr_ycnt_ep),
				.wr_size(wr_size_ep),
				.wdata(hwdata[7:0]),
				.ack(in_ack[n+1]),
				.cfg(ep_cfg[8*n+7:8*n]),
				.ycnt(ep_ycnt[8*n+7:8*n]),
				.size(ep_size[8*n+7:8*n]),
				.y_sel(in_ep_y_sel[n]),
				.done(ep_done[n])
			);
			assign in_ep_serve[n+1] = ep_cfg[8*n+`UIED_B_MANAGER_USE_ENABLE];
			assign in_ep_stall[n] = ep_cfg[8*n+`UIED_B_STALL];
			assign in_ep_toggle[n] = ep_cfg[8*n+`UIED_B_TOGGLE];
			assign in_ep_y_nak[n] = ep_ycnt[8*n+`UIED_B_NAK];
			assign in_ep_y_count[7*n+6:7*n] = ep_ycnt[8*n+6:8*n];
			assign in_ep_buf_size[7*n+6:7*n] = ep_size[8*n+6:8*n];
			// Completion reaches the status only with the enable bit set
			assign ep_event[n] = ep_done[n] & ep_cfg[8*n+`UIED_B_IE];
		end
	endgenerate

	// Interrupt status: completions gated by each endpoint's enable
	reg [`UIED_STATUS_W-1:0] irq_status;
	reg [`UIED_STATUS_W-1:0] irq_mask;
	reg [`UIED_STATUS_W-1:0] events;
	wire [`UIED_STATUS_W-1:0] clr;
	integer k;
	wire ev_e0i;
	wire ev_e0o;

	assign ev_e0i = e0i_done & e0i_cfg[`UIED_B_IE];
	assign ev_e0o = e0o_done & e0o_cfg[`UIED_B_IE];

	always @* begin
		events = {`UIED_STATUS_W{1'b0}};
		events[`UIED_S_EP0_IN] = ev_e0i;
		events[`UIED_S_EP0_OUT] = ev_e0o;
		for (k = 0; k < N_EP; k = k + 1)
			events[k+1] = ep_event[k];
	end

	// Writing zero leaves a bit alone, so one clear cannot hide another event
	assign clr = wr_status ? hwdata[`UIED_STATUS_W-1:0] : {`UIED_STATUS_W{1'b0}};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= {`UIED_STATUS_W{1'b0}};
			irq_mask <= {`UIED_STATUS_W{1'b0}};
		end else begin
			// New event beats a same-cycle clear
			irq_status <= (irq_status & ~clr) | events;
			if (wr_mask)
				irq_mask <= hwdata[`UIED_STATUS_W-1:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// Status and mask read back zero-padded to a byte
	wire [7:0] status_rd;
	wire [7:0] mask_rd;

	assign status_rd = {{(8-`UIED_STATUS_W){1'b0}}, irq_status};
	assign mask_rd = {{(8-`UIED_STATUS_W){1'b0}}, irq_mask};

	// Read data is captured after any preceding write has landed
	reg [7:0] rmux;
	always @* begin
		case (rsel)
			`UIED_SEL_E0I_CFG: rmux = e0i_cfg;
			`UIED_SEL_E0I_CNT: rmux = e0i_cnt;
			`UIED_SEL_E0O_CFG: rmux = e0o_cfg;
			`UIED_SEL_E0O_CNT: rmux = e0o_cnt;
			`UIED_SEL_STATUS: rmux = status_rd;
			`UIED_SEL_MASK: rmux = mask_rd;
			`UIED_SEL_CFG1: rmux = ep_cfg[7:0];
			`UIED_SEL_CFG1 + 4'h1: rmux = ep_cfg[15:8];
			`UIED_SEL_CFG1 + 4'h2: rmux = ep_cfg[23:16];
			`UIED_SEL_YCNT1: rmux = ep_ycnt[7:0];
			`UIED_SEL_YCNT1 + 4'h1: rmux = ep_ycnt[15:8];
			`UIED_SEL_YCNT1 + 4'h2: rmux = ep_ycnt[23:16];
			`UIED_SEL_SIZE1: rmux = ep_size[7:0];
			`UIED_SEL_SIZE1 + 4'h1: rmux = ep_size[15:8];
			`UIED_SEL_SIZE1 + 4'h2: rmux = ep_size[23:16];
			default: rmux = 8'h00;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (dp_rd)
			hrdata <= {24'h000000, rmux};
	end
endmodule // uied_top

`default_nettype wire

// ---- dv/tb_uied_top.sv ----
// Self-checking bench for the endpoint descriptor block.
// Assumes one AHB-Lite master and the buffer manager model.
`timescale 1ns/1ps
`default_nettype none
module tb_uied_top;
	localparam logic [31:0] IC = 32'h3fe00, IN = 32'h3fe04, OC = 32'h3fe08, ON = 32'h3fe0c;
	localparam logic [31:0] ST = 32'h3fe40, MK = 32'h3fe44;
	localparam logic [31:0] E1C = 32'h3fd20, Y1 = 32'h3fd38, S1 = 32'h3fd3c;
	logic hclk, hresetn, hsel, hwrite;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, q;
	wire logic hreadyout, hresp, setup_seen, out0_ack, irq;
	wire logic ep0_in_stall, ep0_in_nak, ep0_in_toggle, ep0_out_toggle;
	wire logic ep0_out_serve, ep0_out_stall, ep0_out_nak;
	wire logic [2:0] in_ep_stall, in_ep_toggle;
	wire logic [31:0] hrdata;
	wire logic [3:0] in_ack, out0_rx_count, in_ep_serve, ep0_in_count;
	wire logic [15:0] ep0_in_buf_base, ep0_out_buf_base;
	wire logic [2:0] in_ep_y_sel, in_ep_y_nak;
	wire logic [20:0] in_ep_y_count, in_ep_buf_size;
	int n_fail = 0;
	int n_checks = 0;
	uied_top #(.N_EP(3)) uied_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.in_ack(in_ack), .setup_seen(setup_seen), .out0_ack(out0_ack),
		.out0_rx_count(out0_rx_count), .in_ep_serve(in_ep_serve),
		.ep0_out_serve(ep0_out_serve), .ep0_in_stall(ep0_in_stall),
		.ep0_out_stall(ep0_out_stall), .ep0_in_nak(ep0_in_nak), .ep0_out_nak(ep0_out_nak),
		.ep0_in_toggle(ep0_in_toggle), .ep0_out_toggle(ep0_out_toggle),
		.ep0_in_count(ep0_in_count), .ep0_in_buf_base(ep0_in_buf_base),
		.ep0_out_buf_base(ep0_out_buf_base), .in_ep_stall(in_ep_stall),
		.in_ep_toggle(in_ep_toggle), .in_ep_y_sel(in_ep_y_sel), .in_ep_y_nak(in_ep_y_nak),
		.in_ep_y_count(in_ep_y_count), .in_ep_buf_size(in_ep_buf_size), .irq(irq));
	uied_mgr_model uied_mgr_model_i (.hclk(hclk), .in_ack(in_ack), .setup_seen(setup_seen),
		.out0_ack(out0_ack), .out0_rx_count(out0_rx_count));
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One single transfer; read data lands in q
	task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		#1;
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		xf(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		n_fail++;
		report_and_stop;
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rc(IC, 32'h0);
		rc(IN, 32'h80);
		rc(Y1, 32'h80);
		chk(ep0_in_buf_base, 32'hfef8);
		chk(ep0_out_buf_base, 32'hfef0);
		xf(1'b1, Y1, 32'h40);
		rc(Y1, 32'h40);
		chk(in_ep_y_count[6:0], 32'h40);
		chk(in_ep_y_nak[0], 32'h0);
		xf(1'b1, S1, 32'h40);
		rc(S1, 32'h40);
		chk(in_ep_buf_size[6:0], 32'h40);
		for (int c = 0; c < 16; c++) begin
			xf(1'b1, IN, c);
			chk(ep0_in_count, (c > 8) ? 8 : c);
		end
		xf(1'b1, IN, 32'h7f);
		rc(IN, 32'h0f);
		xf(1'b1, MK, 32'h11);
		xf(1'b1, IC, 32'hff);
		rc(IC, 32'h8c);
		chk(ep0_in_stall, 32'h1);
		uied_mgr_model_i.ev(4'h0, 1'b1, 1'b0, 4'h0, 2);
		chk({ep0_in_stall, ep0_in_toggle}, 32'h1);
		xf(1'b1, IN, 32'h05);
		chk(ep0_in_nak, 32'h0);
		uied_mgr_model_i.ev(4'h1, 1'b0, 1'b0, 4'h0, 0);
		chk({ep0_in_toggle, ep0_in_nak, irq}, 32'h3);
		rc(ST, 32'h01);
		xf(1'b1, ST, 32'h01);
		chk(irq, 32'h0);
		xf(1'b1, IC, 32'h80);
		uied_mgr_model_i.ev(4'h1, 1'b0, 1'b0, 4'h0, 1);
		chk({ep0_in_toggle, irq}, 32'h2);
		rc(ST, 32'h0);
		xf(1'b1, IC, 32'h04);
		uied_mgr_model_i.ev(4'h1, 1'b0, 1'b0, 4'h0, 0);
		chk({in_ep_serve[0], ep0_in_toggle}, 32'h1);
		rc(ST, 32'h0);
		xf(1'b1, OC, 32'h84);
		uied_mgr_model_i.ev(4'h0, 1'b0, 1'b1, 4'h3, 1);
		rc(ON, 32'h83);
		chk({ep0_out_toggle, irq}, 32'h1);
		chk({ep0_out_serve, ep0_out_stall, ep0_out_nak}, 32'h5);
		rc(ST, 32'h10);
		xf(1'b1, E1C, 32'hb0);
		chk(in_ep_y_sel[0], 32'h1);
		chk({in_ep_stall[0], in_ep_toggle[0]}, 32'h1);
		uied_mgr_model_i.ev(4'h2, 1'b0, 1'b0, 4'h0, 0);
		chk({in_ep_y_nak[0], in_ep_y_sel[0], in_ep_toggle[0]}, 32'h4);
		xf(1'b1, E1C, 32'ha0);
		chk(in_ep_y_sel[0], 32'h0);
		xf(1'b1, 32'h4, 32'hff);
		rc(32'h4, 32'h0);
		rc(32'h1003fe00, 32'h0);
		report_and_stop;
	end
endmodule // tb_uied_top
`default_nettype wire

// ---- dv/uied_mgr_model.sv ----
// Buffer manager and host side: completion and setup pulses.
// Assumes pulses one cycle long, launched right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module uied_mgr_model (
	input wire logic hclk,
	output logic [3:0] in_ack,
	output logic setup_seen,
	output logic out0_ack,
	output logic [3:0] out0_rx_count
);
	initial begin
		in_ack = 4'h0;
		setup_seen = 1'b0;
		out0_ack = 1'b0;
		out0_rx_count = 4'h0;
	end
	// Slow answers are modelled by idle cycles before the pulse
	task automatic ev(input logic [3:0] a, input logic s, input logic o, input logic [3:0] n,
		input int slow);
		repeat (slow) @(posedge hclk);
		@(posedge hclk);
		in_ack <= a;
		setup_seen <= s;
		out0_ack <= o;
		out0_rx_count <= n;
		@(posedge hclk);
		in_ack <= 4'h0;
		setup_seen <= 1'b0;
		out0_ack <= 1'b0;
		// Count no longer valid once the pulse is gone
		out0_rx_count <= ~n;
		#1;
	endtask
endmodule // uied_mgr_model
`default_nettype wire

// ---- dv/uied_top_asserts.sv ----
// Port-level checks of the endpoint descriptor block.
// Assumes hready is tied to hreadyout and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module uied_top_asserts #(
	parameter N_EP = 3
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [N_EP:0] in_ack,
	input wire logic setup_seen,
	input wire logic [N_EP:0] in_ep_serve,
	input wire logic ep0_in_stall,
	input wire logic ep0_in_nak,
	input wire logic ep0_in_toggle,
	input wire logic [3:0] ep0_in_count,
	input wire logic [15:0] ep0_in_buf_base,
	input wire logic [15:0] ep0_out_buf_base,
	input wire logic [N_EP-1:0] in_ep_toggle,
	input wire logic [N_EP-1:0] in_ep_y_sel
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_taken;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence wr_taken;
		hsel && hready && htrans[1] && hwrite;
	endsequence
	// Setup overrides the ack, so it is kept out of the ack checks
	sequence ack0;
		in_ack[0] && !setup_seen;
	endsequence
	a_read_one_wait: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_no_wait: assert property (wr_taken |=> hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_fixed_bases: assert property (ep0_in_buf_base == 16'hfef8 && ep0_out_buf_base == 16'hfef0)
		else $error("buffer base wrong");
	a_count_limit: assert property (ep0_in_count <= 4'h8)
		else $error("count above eight");
	a_setup_clears: assert property (setup_seen |=> !ep0_in_stall && ep0_in_toggle)
		else $error("setup left stall");
	a_ack_flips: assert property (ack0 and (in_ep_serve[0] && !ep0_in_stall)
		|=> ep0_in_toggle != $past(ep0_in_toggle) && ep0_in_nak)
		else $error("ack did not flip toggle");
	a_unserved_idle: assert property (ack0 and !in_ep_serve[0] |=> $stable(ep0_in_toggle))
		else $error("disabled endpoint served");
	a_ysel_toggle: assert property ((in_ep_y_sel & ~in_ep_toggle) == '0)
		else $error("Y buffer without toggle");
endmodule // uied_top_asserts
bind uied_top uied_top_asserts #(.N_EP(N_EP)) uied_top_asserts_i (.hclk, .hresetn, .hsel,
	.htrans, .hwrite, .hready, .hreadyout, .hresp, .in_ack, .setup_seen, .in_ep_serve,
	.ep0_in_stall, .ep0_in_nak, .ep0_in_toggle, .ep0_in_count, .ep0_in_buf_base,
	.ep0_out_buf_base, .in_ep_toggle, .in_ep_y_sel);
`default_nettype wire
